// ---- hw/ahb_reg_slave.v ----
// AHB-Lite slave front end: zero wait states, OKAY only
`timescale 1ns/10ps
`include "keypad_defines.vh"
module ahb_reg_slave (
  // Clock and reset
  input  wire                  ref_clk,
  input  wire                  rst,
  // AHB-Lite
  input  wire                  hsel,
  input  wire [31:0]           haddr,
  input  wire [1:0]            htrans,
  input  wire                  hwrite,
  input  wire [2:0]            hsize,
  input  wire                  hready,
  input  wire [31:0]           hwdata,
  output wire                  hreadyout,
  output wire                  hresp,
  output wire [31:0]           hrdata,
  // Register side
  output wire [`KP_ADDR_W-1:0] rd_addr,
  output wire                  rd_en,
  input  wire [7:0]            rd_value,
  output wire                  wr_en,
  output wire [`KP_ADDR_W-1:0] wr_addr,
  output wire [7:0]            wr_data
);

  reg  [7:0]            rdata_reg;
  reg                   wr_pend_reg;
  reg  [`KP_ADDR_W-1:0] wr_addr_reg;
  wire                  xfer;
  wire                  hi_zero;

  // ========================================================
  // Address phase decode
  // Any address above the map decodes to nothing: reads 0, writes dropped
  assign hi_zero = (haddr[31:`KP_ADDR_W] == {(32-`KP_ADDR_W){1'b0}});
  assign xfer    = hsel & hready & htrans[1] & hi_zero;
  assign rd_en   = xfer & ~hwrite;
  assign rd_addr = haddr[`KP_ADDR_W-1:0];

  // Read data is sampled in the address phase so it stands in the data phase
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg   <= 8'h00;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= {`KP_ADDR_W{1'b0}};
    end else begin
      if (hready) begin
        rdata_reg   <= rd_en ? rd_value : 8'h00;
        wr_pend_reg <= xfer & hwrite;
        wr_addr_reg <= haddr[`KP_ADDR_W-1:0];
      end
    end
  end

  // ========================================================
  // Data phase
  assign wr_en     = wr_pend_reg;
  assign wr_addr   = wr_addr_reg;
  assign wr_data   = hwdata[7:0];
  assign hrdata    = {24'h000000, rdata_reg};
  assign hreadyout = 1'b1;
  assign hresp     = `KP_HRESP_OKAY;

endmodule

// ---- hw/keypad_defines.vh ----
// Constants for the keypad pin interrupt unit
`ifndef KEYPAD_DEFINES_VH
`define KEYPAD_DEFINES_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define KP_SC_IDX       8'h1a
`define KP_EN_IDX       8'h1b
`define KP_BRK_IDX      8'h1c
`define KP_SC_ADDR      {`KP_SC_IDX, 2'b00}
`define KP_EN_ADDR      {`KP_EN_IDX, 2'b00}
`define KP_BRK_ADDR     {`KP_BRK_IDX, 2'b00}
`define KP_ADDR_W       10

// ==========================================================
// Status and control field positions
`define KP_MODE_BIT     0
`define KP_MASK_BIT     1
`define KP_ACK_BIT      2
`define KP_FLAG_BIT     3
`define KP_BCE_BIT      0

// ==========================================================
// Reset values
`define KP_EN_RST       8'h00
`define KP_MODE_RST     1'b0
`define KP_MASK_RST     1'b0
`define KP_BCE_RST      1'b0

// ==========================================================
// AHB-Lite encodings
`define KP_HTRANS_NSEQ  2'h2
`define KP_HTRANS_SEQ   2'h3
`define KP_HRESP_OKAY   1'b0

`endif

// ---- hw/keypad_pin_interrupt.v ----
// Keypad pin interrupt unit: eight falling-edge / low-level key inputs
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "keypad_defines.vh"
module keypad_pin_interrupt #(
  parameter PINS = 8
) (
  // Clock and reset
  input  wire            ref_clk,
  input  wire            rst,

  // AHB-Lite register bus
  input  wire            hsel,
  input  wire [31:0]     haddr,
  input  wire [1:0]      htrans,
  input  wire            hwrite,
  input  wire [2:0]      hsize,
  input  wire            hready,
  input  wire [31:0]     hwdata,
  output wire            hreadyout,
  output wire            hresp,
  output wire [31:0]     hrdata,

  // Keypad port pins
  input  wire [PINS-1:0] port_pin,
  input  wire [PINS-1:0] port_direction,
  output wire [PINS-1:0] port_direction_eff,
  output wire [PINS-1:0] pin_pullup_en,

  // CPU interrupt and system state
  input  wire            vector_fetch_ack,
  input  wire            break_active,
  output wire            cpu_irq_req,
  output wire            wakeup_req
);

  // ========================================================
  // Declarations
  wire [PINS-1:0]       pin_level;
  wire [`KP_ADDR_W-1:0] rd_addr;
  wire                  rd_en;
  reg  [7:0]            rd_value;
  wire                  wr_en;
  wire [`KP_ADDR_W-1:0] wr_addr;
  wire [7:0]            wr_data;

  reg  [PINS-1:0]       pin_irq_enables_reg;
  reg                   trigger_select_reg;
  reg                   request_mask_reg;
  reg                   break_clear_enable_reg;

  reg                   pending_reg;
  reg                   pending_next;
  reg                   ack_seen_reg;
  reg                   ack_seen_next;
  reg                   any_low_prev_reg;

  wire                  any_low;
  wire                  fall_event;
  wire                  wr_sc;
  wire                  wr_en_reg;
  wire                  wr_brk;
  wire                  sw_ack;
  wire                  ack;

  // ========================================================
  // Pin synchroniser
  pin_sync #(
    .WIDTH        (PINS)
  ) u_sync (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .pin_async    (port_pin),
    .pin_sync_out (pin_level)
  );

  // ========================================================
  // Bus slave
  ahb_reg_slave u_bus (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_en     (rd_en),
    .rd_value  (rd_value),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  // ========================================================
  // Write decode
  assign wr_sc     = wr_en & (wr_addr == `KP_SC_ADDR);
  assign wr_en_reg = wr_en & (wr_addr == `KP_EN_ADDR);
  assign wr_brk    = wr_en & (wr_addr == `KP_BRK_ADDR);

  // Acknowledge is a strobe only; the ACK bit reads 0, and only level mode remembers it, in ack_seen_reg
  assign sw_ack = wr_sc & wr_data[`KP_ACK_BIT];

  // Break protects the latch from software acknowledge, not from vector fetch, unless software opted in
  assign ack = vector_fetch_ack
             | (sw_ack & (~break_active | break_clear_enable_reg));

  // ========================================================
  // Control registers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trigger_select_reg <= `KP_MODE_RST;
      request_mask_reg   <= `KP_MASK_RST;
    end else if (wr_sc) begin
      trigger_select_reg <= wr_data[`KP_MODE_BIT];
      request_mask_reg   <= wr_data[`KP_MASK_BIT];
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_irq_enables_reg <= `KP_EN_RST;
    end else if (wr_en_reg) begin
      pin_irq_enables_reg <= wr_data[PINS-1:0];
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      break_clear_enable_reg <= `KP_BCE_RST;
    end else if (wr_brk) begin
      break_clear_enable_reg <= wr_data[`KP_BCE_BIT];
    end
  end

  // ========================================================
  // Pin effects
  // Enabled pins get pull-ups and are forced to inputs (direction 0)
  assign pin_pullup_en      = pin_irq_enables_reg;
  assign port_direction_eff = port_direction & ~pin_irq_enables_reg;

  // ========================================================
  // Request detection
  // One shared "any low" term: a second key going down while the
  // first is held produces no new edge, by design
  assign any_low    = |(~pin_level & pin_irq_enables_reg);
  assign fall_event = any_low & ~any_low_prev_reg;

  // Reset the history high so a pin held low at reset cannot re-latch
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      any_low_prev_reg <= 1'b1;
    end else begin
      any_low_prev_reg <= any_low;
    end
  end

  // ========================================================
  // Pending latch
  always @* begin
    pending_next  = pending_reg;
    ack_seen_next = ack_seen_reg;
    if (ack) begin
      if (trigger_select_reg) begin
        ack_seen_next = 1'b1;
      end else begin
        pending_next  = 1'b0;
        ack_seen_next = 1'b0;
      end
    end
    // Level mode: both events needed, in either order
    if (trigger_select_reg && (ack || ack_seen_reg) && !any_low) begin
      pending_next  = 1'b0;
      ack_seen_next = 1'b0;
    end
    // A fresh edge wins over any clear in the same cycle
    if (fall_event) begin
      pending_next  = 1'b1;
      ack_seen_next = 1'b0;
    end
    // Level mode: any enabled pin held low raises the request, so a key
    // enabled while already down is not lost for want of an edge
    if (trigger_select_reg && any_low) begin
      pending_next = 1'b1;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_reg  <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      pending_reg  <= pending_next;
      ack_seen_reg <= ack_seen_next;
    end
  end

  // ========================================================
  // CPU request
  // Runs on the bus clock, which keeps running in wait and stop
  assign cpu_irq_req = pending_reg & ~request_mask_reg;
  assign wakeup_req  = cpu_irq_req;

  // ========================================================
  // Read mux
  always @* begin
    rd_value = 8'h00;
    if (rd_en) begin
      case (rd_addr)
        `KP_SC_ADDR: begin
          rd_value[`KP_FLAG_BIT] = pending_reg;
          rd_value[`KP_ACK_BIT]  = 1'b0;
          rd_value[`KP_MASK_BIT] = request_mask_reg;
          rd_value[`KP_MODE_BIT] = trigger_select_reg;
        end
        `KP_EN_ADDR: begin
          rd_value[PINS-1:0] = pin_irq_enables_reg;
        end
        `KP_BRK_ADDR: begin
          rd_value[`KP_BCE_BIT] = break_clear_enable_reg;
        end
        default: begin
          rd_value = 8'h00;
        end
      endcase
    end
  end

endmodule

// ---- hw/pin_sync.v ----
// Two-stage synchroniser for the keypad port pins
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Pins and synchronised levels
  input  wire [WIDTH-1:0] pin_async,
  output wire [WIDTH-1:0] pin_sync_out
);

  // ========================================================
  // Per-pin flops; idle level is high because of pull-ups
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= pin_async[g];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync_out[g] = sync_reg;
    end
  endgenerate

endmodule

// ---- verif/keypad_pin_interrupt_chk.sv ----
// Port assertions for the keypad pin interrupt unit
`timescale 1ns/10ps
`include "keypad_defines.vh"
module keypad_pin_interrupt_chk (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  // Pins and requests
  input wire [7:0]  port_pin,
  input wire [7:0]  port_direction,
  input wire [7:0]  port_direction_eff,
  input wire [7:0]  pin_pullup_en,
  input wire        vector_fetch_ack,
  input wire        break_active,
  input wire        cpu_irq_req,
  input wire        wakeup_req
);
  logic       wsc, wbk, rsc, mode_sh, mask_sh, bce_sh;
  logic [2:0] hq;
  wire        ap    = hsel && hready && htrans[1];
  wire        allhi = &(port_pin | ~pin_pullup_en);
  // Pin levels steady long enough that no fall is still in the synchroniser
  wire        quiet = (hq == {3{allhi}});
  wire        sack  = wsc && hwdata[`KP_ACK_BIT] && !(break_active && !bce_sh);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {wsc, wbk, rsc, mode_sh, mask_sh, bce_sh, hq} <= '0;
    end else begin
      wsc <= ap && hwrite && haddr == {22'h0, `KP_SC_ADDR};
      wbk <= ap && hwrite && haddr == {22'h0, `KP_BRK_ADDR};
      rsc <= ap && !hwrite && haddr == {22'h0, `KP_SC_ADDR};
      hq <= {hq[1:0], allhi};
      if (wsc) {mask_sh, mode_sh} <= hwdata[1:0];
      if (wbk) bce_sh <= hwdata[`KP_BCE_BIT];
    end
  end
  chk_irq_wake: assert property (wakeup_req == cpu_irq_req)
    else $error("wakeup differs from cpu request");
  chk_dir_force: assert property (
    port_direction_eff == (port_direction & ~pin_pullup_en))
    else $error("enabled pin not forced to input");
  chk_mask_block: assert property (mask_sh |-> !cpu_irq_req)
    else $error("masked request reached cpu");
  chk_fall_irq: assert property (
    $fell(allhi) && $stable(pin_pullup_en) && !mask_sh |-> ##[1:4] cpu_irq_req)
    else $error("pin fall gave no request");
  chk_ack_clear: assert property (
    (vector_fetch_ack || sack) && !mode_sh && quiet |=> !cpu_irq_req)
    else $error("edge mode acknowledge did not clear");
  chk_level_hold: assert property (
    mode_sh && !allhi && quiet && cpu_irq_req |=> cpu_irq_req || mask_sh)
    else $error("level request dropped with pin low");
  chk_break_keep: assert property (
    break_active && !bce_sh && wsc && cpu_irq_req && !vector_fetch_ack
    |=> cpu_irq_req || mask_sh)
    else $error("acknowledge in break cleared request");
  chk_sc_read: assert property (
    rsc |-> hrdata[31:4] == '0 && !hrdata[2] && hrdata[1:0] == {mask_sh, mode_sh})
    else $error("status read value wrong");
endmodule
bind keypad_pin_interrupt keypad_pin_interrupt_chk chk_u (.*);

// ---- verif/keypad_switches.sv ----
// Keypad switch model: a pressed key pulls its pin low
`timescale 1ns/10ps
module keypad_switches (
  // Clock
  input  wire        ref_clk,
  // Keys and pins
  input  wire  [7:0] press,
  input  wire  [7:0] pin_pullup_en,
  output logic [7:0] port_pin
);
  logic flip = 1'b0;
  // A pin without its pull-up floats, so it wanders instead of idling high
  always @(posedge ref_clk) flip <= ~flip;
  always_comb
    for (int i = 0; i < 8; i++)
      port_pin[i] = press[i] ? 1'b0 : (pin_pullup_en[i] | (flip ^ i[0]));
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the keypad pin interrupt unit
`timescale 1ns/10ps
`include "keypad_defines.vh"
module testbench;
  logic        ref_clk = 0, rst = 1, hwrite = 0, vack = 0, brk = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, r;
  logic [7:0]  dir = 0, press = 0, en;
  wire  [7:0]  pins, eff, pull;
  wire         rdy, resp, irq, wake;
  wire  [31:0] hrdata;
  int          n_errors = 0, comparisons = 0, seed = 32'h40af, k, i;
  always #2 ref_clk = ~ref_clk;
  keypad_switches sw_u (.ref_clk(ref_clk), .press(press), .pin_pullup_en(pull), .port_pin(pins));
  keypad_pin_interrupt dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(rdy), .hwdata(hwdata),
    .hreadyout(rdy), .hresp(resp), .hrdata(hrdata), .port_pin(pins), .port_direction(dir),
    .port_direction_eff(eff), .pin_pullup_en(pull), .vector_fetch_ack(vack),
    .break_active(brk), .cpu_irq_req(irq), .wakeup_req(wake));
  task test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task phase;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (rdy === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      test_done;
    end
  endtask
  task xfer(logic w, logic [9:0] a, logic [7:0] d);
    haddr <= {22'h0, a};
    hwrite <= w;
    htrans <= `KP_HTRANS_NSEQ;
    phase;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    phase;
    r = hrdata;
  endtask
  task rd(string nm, logic [9:0] a, logic [31:0] e);
    xfer(0, a, 8'h00);
    chk(nm, r, e);
    chk("resp", {31'h0, resp}, {31'h0, `KP_HRESP_OKAY});
  endtask
  // Fall to request takes three edges; six leaves margin
  task cirq(logic e);
    repeat (6) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  function logic [31:0] sc(logic f, logic m, logic md);
    return {28'h0, f, 1'b0, m, md};
  endfunction
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    rd("sc", `KP_SC_ADDR, 0);
    rd("en", `KP_EN_ADDR, 0);
    rd("brk", `KP_BRK_ADDR, 0);
    rd("void", 10'h200, 0);
    repeat (8) begin
      en = 8'($random(seed));
      dir <= 8'($random(seed));
      xfer(1, `KP_EN_ADDR, en);
      rd("en", `KP_EN_ADDR, {24'h0, en});
      chk("eff", {24'h0, eff}, {24'h0, dir & ~en});
      chk("pull", {24'h0, pull}, {24'h0, en});
    end
    xfer(1, `KP_SC_ADDR, 8'h02);
    xfer(1, `KP_EN_ADDR, 8'hff);
    xfer(1, `KP_SC_ADDR, 8'h06);
    xfer(1, `KP_SC_ADDR, 8'h00);
    cirq(0);
    k = $random(seed) & 7;
    press[k] <= 1;
    cirq(1);
    rd("flag", `KP_SC_ADDR, sc(1, 0, 0));
    xfer(1, `KP_SC_ADDR, 8'h04);
    cirq(0);
    press[(k + 1) & 7] <= 1;
    cirq(0);
    press <= 0;
    cirq(0);
    press[k] <= 1;
    cirq(1);
    vack <= 1;
    @(posedge ref_clk);
    vack <= 0;
    cirq(0);
    press <= 0;
    xfer(1, `KP_SC_ADDR, 8'h02);
    press[k] <= 1;
    cirq(0);
    rd("flag", `KP_SC_ADDR, sc(1, 1, 0));
    xfer(1, `KP_SC_ADDR, 8'h00);
    cirq(1);
    press <= 0;
    xfer(1, `KP_SC_ADDR, 8'h04);
    xfer(1, `KP_SC_ADDR, 8'h01);
    press[k] <= 1;
    cirq(1);
    xfer(1, `KP_SC_ADDR, 8'h05);
    cirq(1);
    press <= 0;
    cirq(0);
    press[k] <= 1;
    cirq(1);
    press <= 0;
    cirq(1);
    xfer(1, `KP_SC_ADDR, 8'h05);
    cirq(0);
    xfer(1, `KP_SC_ADDR, 8'h00);
    press[k] <= 1;
    cirq(1);
    brk <= 1;
    xfer(1, `KP_SC_ADDR, 8'h04);
    cirq(1);
    xfer(1, `KP_BRK_ADDR, 8'h01);
    xfer(1, `KP_SC_ADDR, 8'h04);
    brk <= 0;
    cirq(0);
    press <= 0;
    xfer(1, `KP_SC_ADDR, 8'h01);
    press[k] <= 1;
    cirq(1);
    rst <= 1;
    repeat (2) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, 0);
    rst <= 0;
    @(posedge ref_clk);
    rd("sc", `KP_SC_ADDR, 0);
    test_done;
  end
endmodule
